// file: core/rmid_pkg.sv
// Shared constants for the RAM map and identification register bank
package rmid_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PART_IDENT_HIGH = 6'h1a;
  localparam logic [5:0] IDX_PART_IDENT_LOW = 6'h1b;
  localparam logic [5:0] IDX_MEMORY_SIZE_FIRST = 6'h1c;
  localparam logic [5:0] IDX_MEMORY_SIZE_SECOND = 6'h1d;
  localparam logic [5:0] IDX_RAM_POSITION_INIT = 6'h20;
  localparam logic [5:0] IDX_MAP_STATUS = 6'h21;
  localparam int ADDR_IDX_LSB = 2;
  // Fields of ram_position_init
  localparam int POS_SEG_HI = 7;
  localparam int POS_SEG_LO = 6;
  localparam int POS_BIT_THIRTEEN = 5;
  localparam int POS_BIT_TWELVE = 4;
  localparam int POS_BIT_ELEVEN = 3;
  localparam int POS_HIGH_ALIGN = 0;
  localparam logic [7:0] RAM_POSITION_INIT_RESET = 8'h00;
  // Window geometry inside a 16K segment
  localparam logic [13:0] WINDOW_LOW_END = 14'h3000;
  localparam logic [13:0] WINDOW_HIGH_START = 14'h1000;
  localparam logic [14:0] SEGMENT_BYTES = 15'h4000;
  // RAM sizes of the derivatives
  localparam logic [14:0] RAM_12K = 15'h3000;
  localparam logic [14:0] RAM_6K = 15'h1800;
  localparam logic [14:0] RAM_4K = 15'h1000;
  localparam logic [14:0] RAM_2K = 15'h0800;
  // Memory size values
  localparam logic [7:0] MEMSIZE_FIRST_LARGE = 8'h15;
  localparam logic [7:0] MEMSIZE_SECOND_LARGE = 8'h81;
  localparam logic [7:0] MEMSIZE_FIRST_SMALL = 8'h01;
  localparam logic [7:0] MEMSIZE_SECOND_SMALL = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/rmid_regs.sv
// RAM window decode and identification registers behind AXI4-Lite
`timescale 1ns/1ps

module rmid_regs
  import rmid_pkg::*;
#(
  parameter logic [14:0] RAM_BYTES = RAM_12K,
  parameter bit ROM_SMALL = 1'b0,
  // Arbitrary identification values, not tied to any part
  parameter logic [3:0] ID_MAJOR_FAMILY = 4'h7,
  parameter logic [3:0] ID_MINOR_FAMILY = 4'h2,
  parameter logic [3:0] ID_MAJOR_MASK = 4'h0,
  parameter logic [3:0] ID_MINOR_MASK = 4'h1
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic [15:0] cpu_addr_in,
  output logic ram_hit_out,
  output logic reserved_hit_out,
  output logic nonvolatile_ok_out
);

  localparam logic [15:0] PART_ID = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY,
    ID_MAJOR_MASK, ID_MINOR_MASK};
  localparam logic [7:0] MEMSIZE_FIRST =
    ROM_SMALL ? MEMSIZE_FIRST_SMALL : MEMSIZE_FIRST_LARGE;
  localparam logic [7:0] MEMSIZE_SECOND =
    ROM_SMALL ? MEMSIZE_SECOND_SMALL : MEMSIZE_SECOND_LARGE;
  localparam logic [13:0] RAM_LOW_END = RAM_BYTES[13:0];
  localparam logic [13:0] RAM_HIGH_START =
    14'(SEGMENT_BYTES - RAM_BYTES);

  // Position bits that must mirror the align bit on this derivative
  function automatic logic [7:0] unused_mask(input logic [14:0] size);
    logic [7:0] m;
    m = 8'h00;
    if (size <= RAM_6K)
      m[POS_BIT_THIRTEEN] = 1'b1;
    if (size <= RAM_4K)
      m[POS_BIT_TWELVE] = 1'b1;
    if (size <= RAM_2K)
      m[POS_BIT_ELEVEN] = 1'b1;
    return m;
  endfunction

  function automatic logic [31:0] read_value(input logic [5:0] idx,
                                             input logic [7:0] pos,
                                             input logic ok);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      IDX_PART_IDENT_HIGH: v[7:0] = PART_ID[15:8];
      IDX_PART_IDENT_LOW: v[7:0] = PART_ID[7:0];
      IDX_MEMORY_SIZE_FIRST: v[7:0] = MEMSIZE_FIRST;
      IDX_MEMORY_SIZE_SECOND: v[7:0] = MEMSIZE_SECOND;
      IDX_RAM_POSITION_INIT: v[7:0] = pos;
      IDX_MAP_STATUS: v[0] = ok;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return idx == IDX_PART_IDENT_HIGH || idx == IDX_PART_IDENT_LOW ||
      idx == IDX_MEMORY_SIZE_FIRST || idx == IDX_MEMORY_SIZE_SECOND ||
      idx == IDX_RAM_POSITION_INIT || idx == IDX_MAP_STATUS;
  endfunction

  logic aw_held;
  logic [5:0] aw_idx;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [7:0] ram_position_init;
  logic ram_hit;
  logic reserved_hit;
  logic next_aw_held;
  logic [5:0] next_aw_idx;
  logic next_w_held;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] next_ram_position_init;
  logic next_ram_hit;
  logic next_reserved_hit;
  logic wr_go;
  logic rd_go;
  logic align_ok;
  logic in_seg;
  logic high_align;
  logic [13:0] seg_off;

  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;
  assign ram_hit_out = ram_hit;
  assign reserved_hit_out = reserved_hit;
  assign nonvolatile_ok_out = !ram_hit && !reserved_hit;

  assign wr_go = aw_held && w_held && !bvalid;
  assign rd_go = s_axi_arvalid_in && !rvalid;
  // Only reported; software owns keeping these bits in step
  assign align_ok = ((ram_position_init ^
    {8{ram_position_init[POS_HIGH_ALIGN]}}) &
    unused_mask(RAM_BYTES)) == 8'h00;
  assign in_seg =
    cpu_addr_in[15:14] == ram_position_init[POS_SEG_HI:POS_SEG_LO];
  assign high_align = ram_position_init[POS_HIGH_ALIGN];
  assign seg_off = cpu_addr_in[13:0];

  // Bus channels and the writable position register
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ram_position_init = ram_position_init;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr_in[ADDR_IDX_LSB +: 6];
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata_in[7:0];
      next_w_lane0 = s_axi_wstrb_in[0];
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      // Identification and size registers take no write
      if (aw_idx == IDX_RAM_POSITION_INIT && w_lane0)
        next_ram_position_init = w_byte;
    end
    if (bvalid && s_axi_bready_in)
      next_bvalid = 1'b0;
    if (rvalid && s_axi_rready_in)
      next_rvalid = 1'b0;
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rdata = read_value(s_axi_araddr_in[ADDR_IDX_LSB +: 6],
        ram_position_init, align_ok);
      next_rresp = is_mapped(s_axi_araddr_in[ADDR_IDX_LSB +: 6]) ?
        RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      aw_held <= 1'b0;
      aw_idx <= 6'h00;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      ram_position_init <= RAM_POSITION_INIT_RESET;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ram_position_init <= next_ram_position_init;
    end
  end

  // Window decode; the RAM size picks the split of the 12K window
  always_comb
  begin
    next_ram_hit = 1'b0;
    next_reserved_hit = 1'b0;
    if (in_seg && !high_align)
    begin
      next_ram_hit = seg_off < RAM_LOW_END;
      next_reserved_hit = seg_off >= RAM_LOW_END &&
        seg_off < WINDOW_LOW_END;
    end
    else if (in_seg)
    begin
      next_ram_hit = seg_off >= RAM_HIGH_START;
      next_reserved_hit = seg_off >= WINDOW_HIGH_START &&
        seg_off < RAM_HIGH_START;
    end
  end

  // Registered so the RAM and reserved select outputs come from flip-flops; nonvolatile_ok_out is gated from them
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ram_hit <= 1'b0;
      reserved_hit <= 1'b0;
    end
    else
    begin
      ram_hit <= next_ram_hit;
      reserved_hit <= next_reserved_hit;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  ram_low_a: assert property (
    in_seg && !high_align && seg_off < RAM_LOW_END |=> ram_hit_out)
    else $error("low aligned RAM address not decoded");
  ram_high_a: assert property (
    in_seg && high_align && seg_off >= RAM_HIGH_START |=> ram_hit_out)
    else $error("high aligned RAM address not decoded");
  rsv_low_a: assert property (
    in_seg && !high_align && seg_off >= RAM_LOW_END &&
    seg_off < WINDOW_LOW_END |=> reserved_hit_out && !nonvolatile_ok_out)
    else $error("reserved part of low window not blocked");
  rsv_high_a: assert property (
    in_seg && high_align && seg_off >= WINDOW_HIGH_START &&
    seg_off < RAM_HIGH_START |=> reserved_hit_out && !ram_hit_out)
    else $error("reserved part of high window not blocked");
  outside_free_a: assert property (
    !in_seg |=> nonvolatile_ok_out)
    else $error("address outside window blocked");
  pid_high_a: assert property (
    rd_go && s_axi_araddr_in[7:2] == IDX_PART_IDENT_HIGH |=>
    s_axi_rvalid_out && s_axi_rdata_out == {24'h0, PART_ID[15:8]})
    else $error("part identifier high byte wrong");
  pid_low_a: assert property (
    rd_go && s_axi_araddr_in[7:2] == IDX_PART_IDENT_LOW |=>
    s_axi_rdata_out[3:0] == ID_MINOR_MASK &&
    s_axi_rdata_out[7:4] == ID_MAJOR_MASK)
    else $error("part identifier low byte wrong");
  msz_read_a: assert property (
    rd_go && s_axi_araddr_in[7:2] == IDX_MEMORY_SIZE_SECOND |=>
    s_axi_rdata_out == {24'h0, MEMSIZE_SECOND} &&
    s_axi_rresp_out == RESP_OKAY)
    else $error("memory size value wrong");
  ro_write_a: assert property (
    wr_go && aw_idx != IDX_RAM_POSITION_INIT |=>
    $stable(ram_position_init) && s_axi_bvalid_out)
    else $error("read-only write changed state");

endmodule

// file: dv/rmid_regs_tb.sv
// Self-checking bench for the RAM window decode and ID registers
`timescale 1ns/1ps
module rmid_regs_tb
  import rmid_pkg::*;
;
  localparam int NI = 4;
  // One instance per RAM size; odd ones report the small ROM sizes
  localparam logic [NI-1:0][14:0] RB = {RAM_2K, RAM_4K, RAM_6K, RAM_12K};
  // Arbitrary identification nibbles
  localparam logic [15:0] ID = 16'ha63d;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] cpu_addr = 16'h0;
  wire [NI-1:0] awready, wready, bvalid, arready, rvalid;
  wire [NI-1:0] ram_hit, res_hit, nv_ok;
  wire [NI-1:0][1:0] bresp, rresp;
  wire [NI-1:0][31:0] rdata;
  logic dchk = 1'b0;
  logic [NI-1:0][1:0] bq[$];
  logic [NI-1:0][33:0] rq[$];
  logic [NI-1:0][2:0] dq[$];
  int error_cnt = 0, n_checks = 0, cyc = 0;
  logic [7:0] inits[8] = '{8'h00, 8'h39, 8'h40, 8'h79,
                           8'h80, 8'hb9, 8'hc0, 8'hf9};

  always #2 clk_sys_in = ~clk_sys_in;

  for (genvar g = 0; g < NI; g++)
  begin : g_dut
    rmid_regs #(.RAM_BYTES(RB[g]), .ROM_SMALL(1'(g % 2)),
      .ID_MAJOR_FAMILY(ID[15:12]), .ID_MINOR_FAMILY(ID[11:8]),
      .ID_MAJOR_MASK(ID[7:4]), .ID_MINOR_MASK(ID[3:0])) rmid_regs_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready[g]),
      .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready[g]), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid[g]),
      .s_axi_bready_in(bready), .s_axi_bresp_out(bresp[g]),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready[g]),
      .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid[g]),
      .s_axi_rready_in(rready), .s_axi_rdata_out(rdata[g]),
      .s_axi_rresp_out(rresp[g]), .cpu_addr_in(cpu_addr),
      .ram_hit_out(ram_hit[g]), .reserved_hit_out(res_hit[g]),
      .nonvolatile_ok_out(nv_ok[g]));
  end

  task test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Outputs are settled at the falling edge, handshake lands next rise
  always @(negedge clk_sys_in)
  begin
    logic [NI-1:0][1:0] eb;
    logic [NI-1:0][33:0] er;
    logic [NI-1:0][2:0] ed;
    if (bvalid[0] && bready)
    begin
      eb = bq.pop_front();
      chk("bvalid", {30'h0, bvalid}, {30'h0, {NI{1'b1}}});
      for (int g = 0; g < NI; g++)
        chk("bresp", {32'h0, bresp[g]}, {32'h0, eb[g]});
    end
    if (rvalid[0] && rready)
    begin
      er = rq.pop_front();
      chk("rvalid", {30'h0, rvalid}, {30'h0, {NI{1'b1}}});
      for (int g = 0; g < NI; g++)
        chk("read", {rdata[g], rresp[g]}, er[g]);
    end
    if (dchk)
    begin
      ed = dq.pop_front();
      for (int g = 0; g < NI; g++)
        chk("decode", {31'h0, ram_hit[g], res_hit[g], nv_ok[g]},
          {31'h0, ed[g]});
    end
  end

  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tw, ao, wo;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back({NI{r}});
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk_sys_in);
      ao = awvalid && awready[0];
      wo = wvalid && wready[0];
      @(posedge clk_sys_in);
      if (ao)
        awvalid <= 1'b0;
      if (wo)
        wvalid <= 1'b0;
      ta |= ao;
      tw |= wo;
    end while (!(ta && tw));
    do @(negedge clk_sys_in); while (!bvalid[0]);
    @(posedge clk_sys_in);
    bready <= 1'b0;
  endtask

  // Expected {data, resp} of a read, from the register map and the rules
  function automatic logic [33:0] rexp(logic [7:0] a, logic [7:0] v, int g);
    logic [7:0] m, d;
    logic [1:0] r;
    d = 8'h00;
    r = RESP_OKAY;
    // Position bits left unused by the smaller RAM sizes
    case (RB[g])
      RAM_6K: m = 8'h20;
      RAM_4K: m = 8'h30;
      RAM_2K: m = 8'h38;
      default: m = 8'h00;
    endcase
    case (a)
      8'h68: d = ID[15:8];
      8'h6c: d = ID[7:0];
      8'h70: d = g[0] ? MEMSIZE_FIRST_SMALL : MEMSIZE_FIRST_LARGE;
      8'h74: d = g[0] ? MEMSIZE_SECOND_SMALL : MEMSIZE_SECOND_LARGE;
      8'h80: d = v;
      8'h84: d = {7'h0, (v & m) == (m & {8{v[0]}})};
      default: r = RESP_SLVERR;
    endcase
    return {24'h0, d, r};
  endfunction

  task rd(input logic [7:0] a, input logic [7:0] v);
    bit ok;
    logic [NI-1:0][33:0] e;
    for (int g = 0; g < NI; g++)
      e[g] = rexp(a, v, g);
    rq.push_back(e);
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk_sys_in);
      ok = arready[0];
      @(posedge clk_sys_in);
    end while (!ok);
    arvalid <= 1'b0;
    do @(negedge clk_sys_in); while (!rvalid[0]);
    @(posedge clk_sys_in);
    rready <= 1'b0;
  endtask

  // Expected {ram, reserved, nonvolatile} for an address and position value
  function automatic logic [2:0] dexp(logic [15:0] a, logic [7:0] v,
                                      logic [14:0] sz);
    logic [15:0] o, rb;
    logic r, s;
    o = {2'b00, a[13:0]};
    rb = {1'b0, sz};
    r = 0;
    s = 0;
    if (a[15:14] == v[7:6])
    begin
      r = v[0] ? (o >= 16'h4000 - rb) : (o < rb);
      s = !r && (v[0] ? (o >= 16'h1000) : (o < 16'h3000));
    end
    return {r, s, !(r || s)};
  endfunction

  task probe(input logic [15:0] a, input logic [7:0] v);
    logic [NI-1:0][2:0] e;
    for (int g = 0; g < NI; g++)
      e[g] = dexp(a, v, RB[g]);
    @(posedge clk_sys_in);
    cpu_addr <= a;
    @(posedge clk_sys_in);
    dq.push_back(e);
    dchk <= 1'b1;
    @(posedge clk_sys_in);
    dchk <= 1'b0;
  endtask

  initial
  begin
    logic [15:0] b;
    logic [15:0] offs[14];
    logic [7:0] pos;
    void'($urandom(32'h880b));
    // Every RAM and reserved boundary of all four sizes
    offs = '{16'h0000, 16'h07ff, 16'h0800, 16'h0fff, 16'h1000, 16'h17ff,
             16'h1800, 16'h27ff, 16'h2800, 16'h2fff, 16'h3000, 16'h37ff,
             16'h3800, 16'h3fff};
    pos = RAM_POSITION_INIT_RESET;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(8'h80, pos);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h68 + 8'(4 * i), pos);
      wr(8'h68 + 8'(4 * i), $urandom, RESP_OKAY);
      rd(8'h68 + 8'(4 * i), pos);
    end
    rd(8'hfc, pos);
    wr(8'hfc, $urandom, RESP_SLVERR);
    // Align bit set, unused bits clear: status drops on smaller sizes
    pos = 8'h01;
    wr(8'h80, {24'h0, pos}, RESP_OKAY);
    rd(8'h84, pos);
    foreach (inits[k])
    begin
      pos = inits[k];
      // Position values keep unused bits equal to the align bit
      wr(8'h80, {24'h0, pos}, RESP_OKAY);
      rd(8'h80, pos);
      rd(8'h84, pos);
      for (int s = 0; s < 4; s++)
      begin
        b = {s[1:0], 14'h0};
        foreach (offs[j])
          probe(b + offs[j], pos);
        probe(16'($urandom), pos);
      end
    end
    repeat (3) @(posedge clk_sys_in);
    test_done();
  end
endmodule
